// ---- hdl/drb_diagnostic_record_builder.sv ----
`timescale 1ns/1ps
module drb_diagnostic_record_builder
  import drb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic diagEnable,
  input wire logic isFunctionModule,
  input wire logic [15:0] moduleAddr,
  // Fault sources
  input wire drb_fault_s faults,
  // Process event handler status
  input wire logic processEvent,
  input wire logic processHandlerBusy,
  // Extended record bytes, module specific
  input wire logic [7:0] extDataIn [EXT_DEPTH],
  // Diagnostic handler
  output logic handlerStart,
  output logic handlerOutgoing,
  input wire logic handlerDone,
  output drb_record_s handlerLocal,
  // Record read function
  input wire logic recRead,
  input wire logic recExtended,
  input wire logic [EXT_AW-1:0] recAddr,
  output logic [7:0] recData,
  output logic recValid,
  // Diagnostic buffer readout
  input wire logic [LOG_AW-1:0] logRdAddr,
  output drb_log_s logRdData,
  output logic [LOG_AW:0] logCount
);

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  drb_fault_s liveFaults;
  drb_fault_s prevFaults;
  drb_fault_s next_prevFaults;
  logic repeatEvent;
  logic rising;
  logic falling;

  always_comb begin
    repeatEvent = processEvent & processHandlerBusy;
    liveFaults = faults;
    liveFaults.lostEvent = faults.lostEvent | repeatEvent;
    next_prevFaults = liveFaults;
    rising = |(liveFaults & ~prevFaults);
    falling = (prevFaults != '0) && (liveFaults == '0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevFaults <= '0;
    end else begin
      prevFaults <= next_prevFaults;
    end
  end

  // ----------------------------------------
  // Record capture and handler sequencing
  // ----------------------------------------
  drb_state_e state;
  drb_state_e next_state;
  drb_record_s record;
  drb_record_s next_record;
  drb_record_s ext0;
  drb_record_s next_ext0;
  logic [7:0] extSnap [EXT_DEPTH];
  logic [7:0] next_extSnap [EXT_DEPTH];
  logic next_handlerStart;
  logic next_handlerOutgoing;
  logic pendOut;
  logic next_pendOut;
  logic logWr;
  logic next_logWr;
  logic [LOG_AW-1:0] logWrPtr;
  logic [LOG_AW-1:0] next_logWrPtr;
  logic [LOG_AW:0] next_logCount;
  drb_record_s built;

  always_comb begin
    built = drb_build(liveFaults, isFunctionModule);
    next_state = state;
    next_record = record;
    next_ext0 = ext0;
    next_extSnap = extSnap;
    next_handlerStart = 1'b0;
    next_handlerOutgoing = 1'b0;
    next_pendOut = pendOut | falling;
    next_logWr = 1'b0;
    next_logWrPtr = logWrPtr + LOG_AW'(logWr);
    next_logCount = logCount + (LOG_AW + 1)'(logWr && logCount != (LOG_AW + 1)'(LOG_DEPTH));
    case (state)
      DRB_IDLE: begin
        if (rising) begin
          next_record = built;
          next_ext0 = built;
          next_extSnap = extDataIn;
          if (diagEnable) begin
            next_handlerStart = 1'b1;
            next_logWr = 1'b1;
            next_state = DRB_HANDLER;
          end
        end else if (pendOut && diagEnable) begin
          // A fault that clears in this cycle stays pending
          next_pendOut = falling;
          next_record = built;
          next_handlerStart = 1'b1;
          next_handlerOutgoing = 1'b1;
          next_logWr = 1'b1;
          next_state = DRB_HANDLER;
        end else if (pendOut) begin
          next_pendOut = falling;
        end
      end
      DRB_HANDLER: begin
        if (handlerDone) begin
          next_state = DRB_IDLE;
        end
      end
      default: begin
        next_state = DRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= DRB_IDLE;
      record <= RECORD_RESET;
      ext0 <= RECORD_RESET;
      extSnap <= '{default: 8'h00};
      handlerStart <= 1'b0;
      handlerOutgoing <= 1'b0;
      pendOut <= 1'b0;
      logWr <= 1'b0;
      logWrPtr <= '0;
      logCount <= '0;
    end else begin
      state <= next_state;
      record <= next_record;
      ext0 <= next_ext0;
      extSnap <= next_extSnap;
      handlerStart <= next_handlerStart;
      handlerOutgoing <= next_handlerOutgoing;
      pendOut <= next_pendOut;
      logWr <= next_logWr;
      logWrPtr <= next_logWrPtr;
      logCount <= next_logCount;
    end
  end

  // Record is valid as soon as handlerStart rises
  assign handlerLocal = record;

  // ----------------------------------------
  // Diagnostic buffer
  // ----------------------------------------
  drb_log_s logEntry;

  always_comb begin
    logEntry.outgoing = handlerOutgoing;
    logEntry.moduleAddr = moduleAddr;
    logEntry.rec = record;
  end

  drb_log_mem #(
    .WIDTH($bits(drb_log_s)),
    .DEPTH(LOG_DEPTH),
    .AW(LOG_AW)
  ) u_log (
    .clk_sys(clk_sys),
    .wrEn(logWr),
    .wrAddr(logWrPtr),
    .wrData(logEntry),
    .rdAddr(logRdAddr),
    .rdData(logRdData)
  );

  // ----------------------------------------
  // Record read function
  // ----------------------------------------
  logic [7:0] next_recData;
  logic next_recValid;

  function automatic logic [7:0] drb_pick(input drb_record_s r, input logic [1:0] ofs);
    case (ofs)
      OFS_ERROR_SUMMARY: drb_pick = r.byte0;
      OFS_CLASS_INFO: drb_pick = r.byte1;
      OFS_INTERNAL_SUPPLY: drb_pick = r.byte2;
      OFS_LOST_EVENT: drb_pick = r.byte3;
      default: drb_pick = 8'h00;
    endcase
  endfunction

  always_comb begin
    next_recData = recData;
    next_recValid = recRead;
    if (recRead) begin
      if (!recExtended) begin
        next_recData = (recAddr[EXT_AW-1:2] == '0) ? drb_pick(record, recAddr[1:0]) : 8'h00;
      end else if (recAddr[EXT_AW-1:2] == '0) begin
        next_recData = drb_pick(ext0, recAddr[1:0]);
      end else begin
        next_recData = extSnap[recAddr];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      recData <= 8'h00;
      recValid <= 1'b0;
    end else begin
      recData <= next_recData;
      recValid <= next_recValid;
    end
  end

endmodule

// ---- hdl/drb_pkg.sv ----
// Overview of operation
// - Each diagnostic handler call logs cause and reporting module address in buffer.
// - With diagnostic interrupts disabled, the latest event stays readable.
// - When enabled, record bytes are in handler data before handler starts.
// - An extended record with extra information is readable on software request.
// - Byte 0 bit 0 flags module failure from any listed fault cause.
// - Byte 0 bit 1 flags internal error: supply missing or output/sensor short.
// - Byte 0 bit 2 flags external error on missing expansion-bus field supply.
// - Byte 0 bit 3 flags channel error on missing expansion-bus field supply.
// - Byte 0 bit 4 flags missing external supply on expansion-bus supply loss.
// - Byte 1 bits 3..0 hold module class: 1111b digital, 1000b function.
// - Byte 1 bit 4 flags channel information for module-failure causes.
// - Byte 2 bit 4 flags missing internal supply; other bits read zero.
// - Byte 3 bit 6 flags lost process interrupt; other bits read zero.
// - A repeat process event during its own handling raises a diagnostic interrupt.
// - After fault removal, with interrupts enabled, an outgoing record is issued.
package drb_pkg;

  localparam logic [1:0] OFS_ERROR_SUMMARY = 2'h0;
  localparam logic [1:0] OFS_CLASS_INFO = 2'h1;
  localparam logic [1:0] OFS_INTERNAL_SUPPLY = 2'h2;
  localparam logic [1:0] OFS_LOST_EVENT = 2'h3;

  localparam int BIT_MODULE_FAIL = 0;
  localparam int BIT_INTERNAL_ERR = 1;
  localparam int BIT_EXTERNAL_ERR = 2;
  localparam int BIT_CHANNEL_ERR = 3;
  localparam int BIT_EXT_SUPPLY = 4;
  localparam int BIT_CHAN_INFO = 4;
  localparam int BIT_INT_SUPPLY = 4;
  localparam int BIT_LOST_EVENT = 6;

  localparam logic [3:0] CLASS_DIGITAL = 4'hF;
  localparam logic [3:0] CLASS_FUNCTION = 4'h8;

  localparam logic [31:0] RECORD_RESET = 32'h0000_0000;
  localparam int EXT_DEPTH = 16;
  localparam int EXT_AW = 4;
  localparam int LOG_DEPTH = 16;
  localparam int LOG_AW = 4;

  typedef struct packed {
    logic lostEvent;
    logic inputSupplyMissing;
    logic outputSupplyMissing;
    logic outputShort;
    logic sensorShort;
    logic busSupplyMissing;
    logic downstreamDiag;
  } drb_fault_s;

  typedef struct packed {
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] byte1;
    logic [7:0] byte0;
  } drb_record_s;

  typedef struct packed {
    logic outgoing;
    logic [15:0] moduleAddr;
    drb_record_s rec;
  } drb_log_s;

  typedef enum logic [0:0] {DRB_IDLE, DRB_HANDLER} drb_state_e;

  function automatic drb_record_s drb_build(input drb_fault_s f, input logic isFunction);
    drb_record_s r;
    logic supply;
    logic anyFail;
    r = RECORD_RESET;
    supply = f.inputSupplyMissing | f.outputSupplyMissing;
    anyFail = f.lostEvent | supply | f.outputShort | f.sensorShort | f.busSupplyMissing | f.downstreamDiag;
    r.byte0[BIT_MODULE_FAIL] = anyFail;
    r.byte0[BIT_INTERNAL_ERR] = supply | f.outputShort | f.sensorShort;
    r.byte0[BIT_EXTERNAL_ERR] = f.busSupplyMissing;
    r.byte0[BIT_CHANNEL_ERR] = f.busSupplyMissing;
    r.byte0[BIT_EXT_SUPPLY] = f.busSupplyMissing;
    r.byte1[3:0] = isFunction ? CLASS_FUNCTION : CLASS_DIGITAL;
    r.byte1[BIT_CHAN_INFO] = anyFail;
    r.byte2[BIT_INT_SUPPLY] = supply;
    r.byte3[BIT_LOST_EVENT] = f.lostEvent;
    return r;
  endfunction

endpackage

// ---- hdl/drb_log_mem.sv ----
`timescale 1ns/1ps
module drb_log_mem
  import drb_pkg::*;
#(
  parameter int WIDTH = 49,
  parameter int DEPTH = LOG_DEPTH,
  parameter int AW = LOG_AW
) (
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // Read side
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// ---- test/drb_record_monitor.sv ----
`timescale 1ns/1ps
module drb_record_monitor
  import drb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire logic diagEnable,
  input wire logic isFunctionModule,
  input wire logic handlerStart,
  input wire logic handlerDone,
  input wire drb_record_s handlerLocal,
  input wire logic recRead,
  input wire logic recExtended,
  input wire logic [EXT_AW-1:0] recAddr,
  input wire logic [7:0] recData,
  input wire logic recValid,
  input wire logic [LOG_AW:0] logCount
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_START_PULSE: assert property (handlerStart |=> !handlerStart)
    else $error("start pulse too long");
  AST_NEED_ENABLE: assert property (handlerStart |-> $past(diagEnable))
    else $error("start while disabled");
  AST_CLASS: assert property (handlerStart |->
    handlerLocal.byte1[3:0] == ($past(isFunctionModule) ? CLASS_FUNCTION : CLASS_DIGITAL))
    else $error("bad class");
  AST_INFO_FAIL: assert property (handlerStart |-> handlerLocal.byte1[4] == handlerLocal.byte0[0])
    else $error("info flag differs");
  AST_BUS_FLAGS: assert property (handlerStart |->
    handlerLocal.byte0[4:2] inside {3'h0, 3'h7})
    else $error("bus flags split");
  AST_FAIL_CAUSE: assert property (handlerStart && (|{handlerLocal.byte0[4:1], handlerLocal.byte3[6]})
    |-> handlerLocal.byte0[0])
    else $error("failure flag missing");
  AST_SUPPLY_INT: assert property (handlerStart && handlerLocal.byte2[4] |-> handlerLocal.byte0[1])
    else $error("internal flag missing");
  AST_FIXED_ZERO: assert property (
    {handlerLocal.byte2[7:5], handlerLocal.byte2[3:0], handlerLocal.byte3[7], handlerLocal.byte3[5:0]} == 14'h0000)
    else $error("fixed bits set");
  AST_RECORD_HELD: assert property (handlerStart && !handlerDone |=> $stable(handlerLocal))
    else $error("record changed in handler");
  AST_READ_ANSWER: assert property (recRead |=> recValid)
    else $error("read not answered");
  AST_BASIC_RANGE: assert property (recRead && !recExtended && recAddr > 4'h3 |=> recData == 8'h00)
    else $error("basic read beyond record");
  AST_LOG_COUNT: assert property (handlerStart && logCount < 5'h10 |->
    ##[1:2] logCount == $past(logCount) + 5'h01)
    else $error("log count not advanced");
endmodule
bind drb_diagnostic_record_builder drb_record_monitor u_drb_record_monitor (.clk_sys, .rst, .diagEnable,
  .isFunctionModule, .handlerStart, .handlerDone, .handlerLocal, .recRead, .recExtended, .recAddr, .recData,
  .recValid, .logCount);

// ---- test/drb_diagnostic_record_builder_tb.sv ----
`timescale 1ns/1ps
module drb_diagnostic_record_builder_tb
  import drb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic diagEnable = 1'b1, isFunctionModule = 1'b0, processEvent = 1'b0, processHandlerBusy = 1'b0;
  logic handlerDone = 1'b0, recRead = 1'b0, recExtended = 1'b0;
  logic [15:0] moduleAddr = 16'h0000;
  drb_fault_s faults = '0;
  logic [7:0] extDataIn [EXT_DEPTH];
  logic [EXT_AW-1:0] recAddr = '0;
  logic [LOG_AW-1:0] logRdAddr = '0;
  logic [LOG_AW-1:0] logIdx = '0;
  logic handlerStart, handlerOutgoing, recValid;
  logic [7:0] recData;
  logic [LOG_AW:0] logCount;
  drb_record_s handlerLocal;
  drb_log_s logRdData, cur;
  drb_log_s expRec[$];
  logic [7:0] expByte[$];
  int error_cnt = 0, num_checks = 0, cyc = 0, i, n, w;

  drb_diagnostic_record_builder u_drb_diagnostic_record_builder (.clk_sys, .rst, .diagEnable, .isFunctionModule,
    .moduleAddr, .faults, .processEvent, .processHandlerBusy, .extDataIn, .handlerStart, .handlerOutgoing,
    .handlerDone, .handlerLocal, .recRead, .recExtended, .recAddr, .recData, .recValid, .logRdAddr, .logRdData,
    .logCount);

  initial forever #4 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkRec(input drb_log_s got, input drb_log_s exp);
    chk(got, exp);
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    chk({41'h0, got}, {41'h0, exp});
  endtask

  task automatic chkLog(input drb_log_s got, input drb_log_s exp);
    chk(got, exp);
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic drb_log_s mk(input drb_fault_s f, input logic out);
    logic s;
    logic a;
    mk = '0;
    s = f.inputSupplyMissing | f.outputSupplyMissing;
    a = |f;
    mk.outgoing = out;
    mk.moduleAddr = moduleAddr;
    mk.rec.byte0 = {3'h0, {3{f.busSupplyMissing}}, s | f.outputShort | f.sensorShort, a};
    mk.rec.byte1 = {3'h0, a, isFunctionModule ? 4'h8 : 4'hF};
    mk.rec.byte2 = {3'h0, s, 4'h0};
    mk.rec.byte3 = {1'h0, f.lostEvent, 6'h00};
  endfunction

  // Result watcher takes the oldest note per result
  always @(negedge clk_sys) begin
    if (!rst && handlerStart === 1'b1) begin
      if (expRec.size() == 0) chk(49'h1, 49'h0);
      else chkRec({handlerOutgoing, moduleAddr, handlerLocal}, expRec.pop_front());
    end
    if (!rst && recValid === 1'b1) begin
      if (expByte.size() == 0) chk(49'h1, 49'h0);
      else chkByte(recData, expByte.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic waitStart();
    w = 0;
    while (handlerStart !== 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    tick(1);
  endtask

  task automatic rd(input logic ext, input logic [3:0] a, input logic [7:0] e);
    recRead = 1'b1;
    recExtended = ext;
    recAddr = a;
    expByte.push_back(e);
    tick(1);
    recRead = 1'b0;
    tick(1);
  endtask

  task automatic done();
    handlerDone = 1'b1;
    tick(1);
    handlerDone = 1'b0;
    if (diagEnable) begin
      logRdAddr = logIdx;
      tick(2);
      chkLog(logRdData, cur);
      logIdx++;
    end
  endtask

  task automatic fire(input drb_fault_s f, input logic rep);
    cur = mk(f, 1'b0);
    if (diagEnable) expRec.push_back(cur);
    processHandlerBusy = rep;
    processEvent = rep;
    if (!rep) faults = f;
    tick(1);
    processEvent = 1'b0;
    waitStart();
    for (i = 0; i < 4; i++) rd(1'b0, i[3:0], cur.rec[8*i +: 8]);
    rd(1'b1, 4'h1, cur.rec.byte1);
    rd(1'b1, 4'h7, extDataIn[7]);
    rd(1'b0, 4'h9, 8'h00);
    // A lost event clears by itself, so its outgoing call follows the handler at once
    if (diagEnable) expRec.push_back(mk('0, 1'b1));
    done();
    faults = '0;
    processHandlerBusy = 1'b0;
    cur = mk('0, 1'b1);
    if (!rep) waitStart();
    done();
  endtask

  initial begin
    void'($urandom(85214));
    moduleAddr = 16'($urandom);
    foreach (extDataIn[k]) extDataIn[k] = 8'($urandom);
    tick(2);
    rst = 1'b0;
    tick(1);
    for (n = 0; n < 7; n++) fire(drb_fault_s'(7'h01 << n), 1'b0);
    fire(drb_fault_s'(7'h40), 1'b1);
    for (n = 0; n < 6; n++) begin
      isFunctionModule = ~isFunctionModule;
      fire(drb_fault_s'(7'($urandom_range(1, 127))), 1'b0);
    end
    diagEnable = 1'b0;
    fire(drb_fault_s'(7'h02), 1'b0);
    diagEnable = 1'b1;
    fire(drb_fault_s'(7'h21), 1'b0);
    chk(49'(expRec.size() + expByte.size()), 49'h0);
    chk(49'(logCount), 49'(LOG_DEPTH));
    // Reset in mid-run clears every output except logRdData, which has no reset
    rst = 1'b1;
    tick(1);
    chk(49'({handlerStart, handlerOutgoing, recValid, recData, logCount, handlerLocal}), 49'h0);
    report_and_stop();
  end
endmodule
